/* File: design/ata_cmd_core.sv */
// ata_cmd_core: task file, command sequencer and dma pacing.
// assumes the media side answers each sector with done and error flags,
// and host writes only while busy is clear.
//
// Overview of operation
// - opcodes CA and CB start a dma write.
// - opcode bit 0 low retries, high suppresses retries.
// - data words move only while dma request is asserted.
// - device alone raises and drops dma request.
// - dma write posts status once after the whole transfer.
// - fatal error stops transfer; later sectors not accepted.
// - fatal error raises interrupt with standard error status.
// - on error, sector count holds sectors never transferred.
// - set features 03 with 12 or 22 picks dma mode 2.
// - set features 03 with 42 picks ultra dma mode 2.
// - opcode 3C starts a write with verify.
// - each sector is taken from the host by dma, then reread and checked.
// - verify errors report through status and error at end.
// - opcodes 10 to 1F recalibrate to cylinder zero.
// - recalibrate sets busy, seeks, then clears busy, interrupts.
// - recalibrate runs even in lba mode.
// - completion leaves the ending address in the task file.
module ata_cmd_core
    import ata_cmd_pkg::*;
#(
    parameter int WORDS_PER_SECT = 256,
    parameter int SEEK_CYCLES = SEEK_CYC
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // task-file port
    input wire logic [9:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // dma data
    output logic dmarq_o,
    input wire logic dmack_i,
    input wire logic [15:0] ddata_i,
    output logic [15:0] mdata_o,
    output logic mvalid_o,
    // media side
    input wire logic sect_done_i,
    input wire logic sect_err_i,
    input wire logic verify_err_i,
    output logic verify_o,
    output logic no_retry_o,
    output logic seek_zero_o,
    // status
    output logic intrq_o,
    output xfer_mode_e xfer_mode_o
);
    initial begin
        if (WORDS_PER_SECT < 2 || WORDS_PER_SECT > 65536 ||
            SEEK_CYCLES < 1) begin
            $error("ata_cmd_core: parameter out of range");
        end
    end
    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001, S_XFER = 5'b00010, S_MEDIA = 5'b00100,
        S_SEEK = 5'b01000, S_DONE = 5'b10000
    } state_e;
    state_e state_q;
    taskfile_s tf_host_q, tf_cur;
    logic [7:0] feat_q, fault_q, status_val;
    logic [15:0] word_q;
    logic [31:0] seek_q;
    logic verify_q, noret_q, err_q, intrq_q, mvalid_q;
    logic [15:0] mdata_q;
    xfer_mode_e mode_q;
    logic cmd_wr, dec_wdma, dec_noret, dec_ver, dec_recal, dec_sf, dec_bad;
    logic start_x, step, busy, sf_bad;
    logic last_word;

    assign cmd_wr = wr_i && addr_i == ADDR_CMD && state_q == S_IDLE;
    assign busy = state_q != S_IDLE;
    assign last_word = word_q == 16'(WORDS_PER_SECT - 1);
    assign start_x = cmd_wr && (dec_wdma || dec_ver);
    // unsupported feature or transfer subcode is aborted
    assign sf_bad = dec_sf && (feat_q != FEAT_XFER ||
        (tf_host_q.scount != XF_SW_DMA2 && tf_host_q.scount != XF_MW_DMA2 &&
        tf_host_q.scount != XF_UDMA2));

    ata_opcode_dec u_dec (
        .op_i(wdata_i),
        .is_wdma_o(dec_wdma),
        .no_retry_o(dec_noret),
        .is_verify_o(dec_ver),
        .is_recal_o(dec_recal),
        .is_setfeat_o(dec_sf),
        .is_bad_o(dec_bad)
    );

    ata_sector_cnt u_cnt (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        // every command reloads, so the end-of-command copy is never stale
        .load_i(cmd_wr),
        .step_i(step),
        .tf_i(tf_host_q),
        .tf_o(tf_cur)
    );
    // a failed sector still crossed the bus, so it leaves the residual
    assign step = state_q == S_MEDIA && sect_done_i;

    // ------------------------------------------------------------
    // host-written task file
    // ------------------------------------------------------------
    // writes while busy dropped
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tf_host_q <= '0;
            feat_q <= RST_ZERO;
        end else if (wr_i && !busy) begin
            unique case (addr_i)
                ADDR_FAULT: feat_q <= wdata_i;
                ADDR_SCOUNT: tf_host_q.scount <= wdata_i;
                ADDR_SNUM: tf_host_q.snum <= wdata_i;
                ADDR_CYLLO: tf_host_q.cyllo <= wdata_i;
                ADDR_CYLHI: tf_host_q.cylhi <= wdata_i;
                ADDR_DHEAD: tf_host_q.dhead <= wdata_i;
                default: ;
            endcase
        end else if (state_q == S_DONE) begin
            tf_host_q <= tf_cur;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            word_q <= '0;
            seek_q <= '0;
            verify_q <= 1'b0;
            noret_q <= 1'b0;
            err_q <= 1'b0;
            fault_q <= RST_ZERO;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (start_x) begin
                        state_q <= S_XFER;
                        word_q <= '0;
                        verify_q <= dec_ver;
                        noret_q <= dec_noret;
                        err_q <= 1'b0;
                        fault_q <= RST_ZERO;
                    end else if (cmd_wr && dec_recal) begin
                        state_q <= S_SEEK;
                        seek_q <= '0;
                        err_q <= 1'b0;
                        fault_q <= RST_ZERO;
                    end else if (cmd_wr) begin
                        err_q <= dec_bad || sf_bad;
                        fault_q <= (dec_bad || sf_bad) ? FLT_ABRT : RST_ZERO;
                        state_q <= S_DONE;
                    end
                end
                S_XFER: begin
                    if (tf_cur.scount == RST_ZERO) begin
                        state_q <= S_DONE;
                    end else if (dmack_i) begin
                        word_q <= word_q + 16'h0001;
                        if (last_word) begin
                            word_q <= '0;
                            state_q <= S_MEDIA;
                        end
                    end
                end
                S_MEDIA: begin
                    if (sect_done_i) begin
                        if (sect_err_i || verify_err_i) begin
                            err_q <= 1'b1;
                            fault_q <= FLT_UNC;
                            state_q <= S_DONE;
                        end else begin
                            state_q <= S_XFER;
                        end
                    end
                end
                S_SEEK: begin
                    seek_q <= seek_q + 32'h0000_0001;
                    if (seek_q == 32'(SEEK_CYCLES - 1)) begin
                        state_q <= S_DONE;
                    end
                end
                S_DONE: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_q <= XF_PIO;
        end else if (cmd_wr && dec_sf && feat_q == FEAT_XFER) begin
            if (tf_host_q.scount == XF_SW_DMA2) begin
                mode_q <= XF_SW;
            end else if (tf_host_q.scount == XF_MW_DMA2) begin
                mode_q <= XF_MW;
            end else if (tf_host_q.scount == XF_UDMA2) begin
                mode_q <= XF_UDMA;
            end
        end
    end

    // ------------------------------------------------------------
    // dma data path
    // ------------------------------------------------------------
    // words gated by request
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mdata_q <= '0;
            mvalid_q <= 1'b0;
        end else begin
            mvalid_q <= dmarq_o && dmack_i;
            if (dmarq_o && dmack_i) begin
                mdata_q <= ddata_i;
            end
        end
    end
    assign dmarq_o = state_q == S_XFER && tf_cur.scount != RST_ZERO;

    // ------------------------------------------------------------
    // status and interrupt
    // ------------------------------------------------------------
    // single status post
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            intrq_q <= 1'b0;
        end else if (state_q == S_DONE) begin
            intrq_q <= 1'b1;
        end else if ((rd_i && addr_i == ADDR_CMD) || cmd_wr) begin
            intrq_q <= 1'b0;
        end
    end

    always_comb begin
        status_val = RST_ZERO;
        status_val[STS_BSY] = busy;
        status_val[STS_DRDY] = 1'b1;
        status_val[STS_DSC] = !(state_q == S_SEEK);
        status_val[STS_ERR] = err_q;
    end

    always_comb begin
        unique case (addr_i)
            ADDR_FAULT: rdata_o = fault_q;
            ADDR_SCOUNT: rdata_o = tf_host_q.scount;
            ADDR_SNUM: rdata_o = tf_host_q.snum;
            ADDR_CYLLO: rdata_o = tf_host_q.cyllo;
            ADDR_CYLHI: rdata_o = tf_host_q.cylhi;
            ADDR_DHEAD: rdata_o = tf_host_q.dhead;
            ADDR_CMD: rdata_o = status_val;
            default: rdata_o = RST_ZERO;
        endcase
    end

    assign intrq_o = intrq_q;
    assign mdata_o = mdata_q;
    assign mvalid_o = mvalid_q;
    assign verify_o = verify_q;
    assign no_retry_o = noret_q;
    assign seek_zero_o = state_q == S_SEEK;
    assign xfer_mode_o = mode_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    dma_gate_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        mvalid_q |-> $past(dmarq_o)
    ) else $error("word without request");
    req_idle_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        state_q == S_IDLE |-> !dmarq_o
    ) else $error("request while idle");
    err_stop_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_q == S_MEDIA && sect_done_i && sect_err_i) |=>
        state_q == S_DONE ##1 !dmarq_o
    ) else $error("no stop on error");
    err_irq_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_q == S_MEDIA && sect_done_i && sect_err_i) |=> ##1
        (intrq_o && err_q)
    ) else $error("error without interrupt");
    residual_cnt_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_q == S_MEDIA && sect_done_i) |=>
        tf_cur.scount == $past(tf_cur.scount) - RST_ONE
    ) else $error("residual count not stepped");
    verify_err_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_q == S_MEDIA && sect_done_i && verify_err_i) |=>
        (state_q == S_DONE && err_q && fault_q == FLT_UNC)
    ) else $error("verify error not posted");
    irq_once_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(intrq_q) |-> $past(state_q) == S_DONE
    ) else $error("interrupt mid command");
    recal_busy_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (cmd_wr && dec_recal) |=> busy [*2]
    ) else $error("recal not busy");
    recal_irq_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_q == S_SEEK && seek_q == 32'(SEEK_CYCLES - 1)) |=> ##1
        (intrq_o && !busy)
    ) else $error("recal end without interrupt");
    mode_sel_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (cmd_wr && dec_sf && feat_q == FEAT_XFER &&
        tf_host_q.scount == XF_UDMA2) |=> mode_q == XF_UDMA
    ) else $error("ultra mode not taken");
    mw_sel_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (cmd_wr && dec_sf && feat_q == FEAT_XFER &&
        tf_host_q.scount == XF_MW_DMA2) |=> mode_q == XF_MW
    ) else $error("multiword mode not taken");
    sw_sel_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (cmd_wr && dec_sf && feat_q == FEAT_XFER &&
        tf_host_q.scount == XF_SW_DMA2) |=> mode_q == XF_SW
    ) else $error("single word mode not taken");
    retry_bit_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        start_x |=> noret_q == $past(wdata_i[0] && dec_wdma)
    ) else $error("retry bit lost");
endmodule : ata_cmd_core

/* File: design/ata_cmd_pkg.sv */
// ata_cmd_pkg: shared constants and carriers for the command interpreter.
// assumes a single 25 MHz clock and byte-wide task-file access.
package ata_cmd_pkg;
    // ------------------------------------------------------------
    // task-file addresses
    // ------------------------------------------------------------
    localparam logic [9:0] ADDR_FAULT = 10'h1f1;
    localparam logic [9:0] ADDR_SCOUNT = 10'h1f2;
    localparam logic [9:0] ADDR_SNUM = 10'h1f3;
    localparam logic [9:0] ADDR_CYLLO = 10'h1f4;
    localparam logic [9:0] ADDR_CYLHI = 10'h1f5;
    localparam logic [9:0] ADDR_DHEAD = 10'h1f6;
    localparam logic [9:0] ADDR_CMD = 10'h1f7;
    // ------------------------------------------------------------
    // opcodes and feature values
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WDMA_RETRY = 8'h00ca;
    localparam logic [7:0] OP_WDMA_NORETRY = 8'h00cb;
    localparam logic [7:0] OP_WVERIFY = 8'h003c;
    localparam logic [3:0] OP_RECAL_HI = 4'h1;
    localparam logic [7:0] OP_SETFEAT = 8'h00ef;
    localparam logic [7:0] FEAT_XFER = 8'h0003;
    localparam logic [7:0] XF_SW_DMA2 = 8'h0012;
    localparam logic [7:0] XF_MW_DMA2 = 8'h0022;
    localparam logic [7:0] XF_UDMA2 = 8'h0042;
    // ------------------------------------------------------------
    // status and error bits
    // ------------------------------------------------------------
    localparam int STS_BSY = 7;
    localparam int STS_DRDY = 6;
    localparam int STS_DSC = 4;
    localparam int STS_ERR = 0;
    localparam logic [7:0] FLT_ABRT = 8'h0004;
    localparam logic [7:0] FLT_UNC = 8'h0040;
    localparam int HSEL_LBA = 6;
    // ------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int SEEK_US = 2;
    localparam int SEEK_CYC = (SEEK_US * (CLK_HZ / 1_000_000) > 0) ?
        SEEK_US * (CLK_HZ / 1_000_000) : 1;
    localparam logic [7:0] RST_ONE = 8'h0001;
    localparam logic [7:0] RST_ZERO = 8'h0000;

    typedef enum logic [1:0] {
        XF_PIO = 2'h0, XF_SW = 2'h1, XF_MW = 2'h2, XF_UDMA = 2'h3
    } xfer_mode_e;

    typedef struct packed {
        logic [7:0] scount;
        logic [7:0] snum;
        logic [7:0] cyllo;
        logic [7:0] cylhi;
        logic [7:0] dhead;
    } taskfile_s;
endpackage : ata_cmd_pkg

/* File: design/ata_opcode_dec.sv */
// ata_opcode_dec: combinational classification of a command byte.
// assumes the byte is the value just written to the command register.
module ata_opcode_dec
    import ata_cmd_pkg::*;
(
    // command in
    input wire logic [7:0] op_i,
    // class out
    output logic is_wdma_o,
    output logic no_retry_o,
    output logic is_verify_o,
    output logic is_recal_o,
    output logic is_setfeat_o,
    output logic is_bad_o
);
    always_comb begin
        is_wdma_o = (op_i == OP_WDMA_RETRY) || (op_i == OP_WDMA_NORETRY);
        no_retry_o = is_wdma_o & op_i[0];
        is_verify_o = (op_i == OP_WVERIFY);
        is_recal_o = (op_i[7:4] == OP_RECAL_HI);
        is_setfeat_o = (op_i == OP_SETFEAT);
        is_bad_o = !(is_wdma_o | is_verify_o | is_recal_o | is_setfeat_o);
    end
endmodule : ata_opcode_dec

/* File: design/ata_sector_cnt.sv */
// ata_sector_cnt: sector address and residual count tracker.
// assumes one step pulse per sector finished, load on command start.
module ata_sector_cnt
    import ata_cmd_pkg::*;
#(
    parameter int SECT_PER_TRK = 63,
    parameter int HEADS = 16
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // control
    input wire logic load_i,
    input wire logic step_i,
    input wire taskfile_s tf_i,
    // state
    output taskfile_s tf_o
);
    initial begin
        if (SECT_PER_TRK < 1 || SECT_PER_TRK > 255 || HEADS < 1 ||
            HEADS > 16) begin
            $error("ata_sector_cnt: geometry out of range");
        end
    end
    localparam logic [7:0] SPT = 8'(SECT_PER_TRK);
    localparam logic [3:0] MAXH = 4'(HEADS - 1);
    taskfile_s tf_q;
    logic [27:0] lba;
    assign lba = {tf_q.dhead[3:0], tf_q.cylhi, tf_q.cyllo, tf_q.snum} +
        28'h000_0001;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tf_q <= '0;
        end else if (load_i) begin
            tf_q <= tf_i;
        end else if (step_i) begin
            tf_q.scount <= tf_q.scount - RST_ONE;
            if (tf_q.dhead[HSEL_LBA]) begin
                {tf_q.dhead[3:0], tf_q.cylhi, tf_q.cyllo, tf_q.snum} <= lba;
            end else if (tf_q.snum < SPT) begin
                tf_q.snum <= tf_q.snum + RST_ONE;
            end else begin
                tf_q.snum <= RST_ONE;
                if (tf_q.dhead[3:0] < MAXH) begin
                    tf_q.dhead[3:0] <= tf_q.dhead[3:0] + 4'h1;
                end else begin
                    tf_q.dhead[3:0] <= 4'h0;
                    {tf_q.cylhi, tf_q.cyllo} <=
                        {tf_q.cylhi, tf_q.cyllo} + 16'h0001;
                end
            end
        end
    end
    assign tf_o = tf_q;
endmodule : ata_sector_cnt

/* File: testbench/host_dma_model.sv */
// host_dma_model: host side of the dma data phase, word strobe and data.
// assumes inputs change only at the falling edge, design samples rising.
module host_dma_model (
    // clock
    input wire logic sys_clk_i,
    // control
    input wire logic dmarq_i,
    input wire logic slow_i,
    // dma data
    output logic dmack_o,
    output logic [15:0] ddata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] word_q = 16'h0000;
    logic ph_q = 1'b0;
    initial dmack_o = 1'b0;
    initial ddata_o = 16'hffff;
    // ------------------------------------------------------------
    // word pacing
    // ------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        if (dmack_o && dmarq_i) begin
            word_q <= word_q + 16'h0001;
        end
    end
    // data phase follows the command
    // slow mode stalls every other cycle so the device sees a lagging host
    always @(negedge sys_clk_i) begin
        ph_q <= ~ph_q;
        dmack_o <= dmarq_i && !(slow_i && ph_q);
        // released bus shows the inverse so a stale word never matches
        ddata_o <= (dmarq_i && !(slow_i && ph_q)) ? 16'ha000 + word_q
                                                  : ~(16'ha000 + word_q);
    end
endmodule : host_dma_model

/* File: testbench/tb.sv */
// tb: self-checking bench for the command interpreter core.
// assumes four words per sector and a four cycle seek for short runs.
module tb;
    import ata_cmd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 4;
    localparam int SK = 4;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [9:0] addr_i = 10'h01f7;
    logic [7:0] wdata_i = 8'h00, rdata_o, rv;
    logic dmarq_o, dmack_i, mvalid_o, intrq_o, verify_o, no_retry_o;
    logic seek_zero_o, slow = 1'b0, rq_prev = 1'b0;
    logic sect_done_i = 1'b0, sect_err_i = 1'b0, verify_err_i = 1'b0;
    logic [15:0] ddata_i, mdata_o;
    xfer_mode_e xfer_mode_o;
    int error_cnt = 0, checks = 0, words = 0, irqs = 0, sidx = 0;
    int err_at = -1, verr_at = -1;
    int wtot = 0;
    logic irq_prev = 1'b0;
    always #20 sys_clk_i = ~sys_clk_i;
    ata_cmd_core #(.WORDS_PER_SECT(W), .SEEK_CYCLES(SK)) ata_cmd_core_inst (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
        .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .dmarq_o(dmarq_o), .dmack_i(dmack_i), .ddata_i(ddata_i),
        .mdata_o(mdata_o), .mvalid_o(mvalid_o), .sect_done_i(sect_done_i),
        .sect_err_i(sect_err_i), .verify_err_i(verify_err_i),
        .verify_o(verify_o), .no_retry_o(no_retry_o),
        .seek_zero_o(seek_zero_o), .intrq_o(intrq_o),
        .xfer_mode_o(xfer_mode_o));
    host_dma_model host_dma_model_inst (.sys_clk_i(sys_clk_i),
        .dmarq_i(dmarq_o), .slow_i(slow), .dmack_o(dmack_i),
        .ddata_o(ddata_i));
    // ------------------------------------------------------------
    // observers and media responder
    // ------------------------------------------------------------
    // the host model numbers words across all commands, so track a total
    always @(negedge sys_clk_i) begin
        if (mvalid_o === 1'b1) begin
            if (mdata_o !== 16'ha000 + wtot) begin
                error_cnt++;
                $display("MISMATCH %0t media word out of order", $time);
            end
            words++;
            wtot++;
        end
        if (intrq_o === 1'b1 && irq_prev !== 1'b1) irqs++;
        irq_prev = intrq_o;
    end
    always @(negedge sys_clk_i) begin
        if (rq_prev && dmarq_o !== 1'b1) begin
            repeat (2) @(negedge sys_clk_i);
            sect_done_i = 1'b1;
            sect_err_i = (sidx == err_at);
            verify_err_i = (sidx == verr_at);
            @(negedge sys_clk_i);
            {sect_done_i, sect_err_i, verify_err_i} = 3'b000;
            sidx++;
        end
        rq_prev = (dmarq_o === 1'b1);
    end
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        {addr_i, wdata_i, wr_i} = {a, d, 1'b1};
        @(negedge sys_clk_i);
        wr_i = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        {addr_i, rd_i} = {a, 1'b1};
        @(posedge sys_clk_i);
        d = rdata_o;
        @(negedge sys_clk_i);
        rd_i = 1'b0;
    endtask : rd_reg
    task automatic issue(input logic [7:0] op, input logic [7:0] sc,
                         input logic [7:0] dh);
        words = 0; irqs = 0; sidx = 0;
        // address and count before the command
        wr_reg(ADDR_SCOUNT, sc);
        wr_reg(ADDR_SNUM, 8'h01);
        wr_reg(ADDR_CYLLO, 8'h05);
        wr_reg(ADDR_CYLHI, 8'h00);
        wr_reg(ADDR_DHEAD, dh);
        wr_reg(ADDR_CMD, op);
    endtask : issue
    task automatic finish(input logic err, input logic [7:0] fault);
        int n;
        n = 0;
        while (intrq_o !== 1'b1 && n < 2000) begin
            @(negedge sys_clk_i);
            n++;
        end
        check(intrq_o, 1'b1);
        rd_reg(ADDR_CMD, rv);
        check(rv[STS_BSY], 1'b0);
        check(rv[STS_ERR], err);
        check(intrq_o, 1'b0);
        check(irqs, 1);
        rd_reg(ADDR_FAULT, rv);
        if (err) check(rv, fault);
    endtask : finish
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_dma_ok();
        issue(OP_WDMA_RETRY, 8'h02, 8'h00);
        check(no_retry_o, 1'b0);
        rd_reg(ADDR_CMD, rv);
        check(rv[STS_BSY], 1'b1);
        finish(1'b0, 8'h00);
        check(words, 2 * W);
        rd_reg(ADDR_SCOUNT, rv);
        check(rv, 8'h00);
        rd_reg(ADDR_SNUM, rv);
        check(rv, 8'h03);
        rd_reg(ADDR_CYLLO, rv);
        check(rv, 8'h05);
    endtask : t_dma_ok
    task automatic t_dma_fatal();
        slow = 1'b1;
        err_at = 1;
        issue(OP_WDMA_NORETRY, 8'h03, 8'h00);
        check(no_retry_o, 1'b1);
        finish(1'b1, FLT_UNC);
        check(words, 2 * W);
        check(dmarq_o, 1'b0);
        rd_reg(ADDR_SCOUNT, rv);
        check(rv, 8'h01);
        slow = 1'b0;
        err_at = -1;
    endtask : t_dma_fatal
    task automatic t_verify();
        verr_at = 0;
        issue(OP_WVERIFY, 8'h01, 8'h00);
        check(verify_o, 1'b1);
        check(no_retry_o, 1'b0);
        finish(1'b1, FLT_UNC);
        check(words, W);
        verr_at = -1;
    endtask : t_verify
    task automatic t_setfeat();
        logic [7:0] sub [3] = '{XF_SW_DMA2, XF_MW_DMA2, XF_UDMA2};
        xfer_mode_e md [3] = '{XF_SW, XF_MW, XF_UDMA};
        for (int i = 0; i < 3; i++) begin
            wr_reg(ADDR_FAULT, FEAT_XFER);
            issue(OP_SETFEAT, sub[i], 8'h00);
            finish(1'b0, 8'h00);
            check(xfer_mode_o, md[i]);
        end
        wr_reg(ADDR_FAULT, FEAT_XFER);
        issue(OP_SETFEAT, 8'h55, 8'h00);
        finish(1'b1, FLT_ABRT);
        check(xfer_mode_o, XF_UDMA);
    endtask : t_setfeat
    task automatic t_recal(input logic [7:0] op);
        int n;
        n = 0;
        // lba bit set: the command must still run
        issue(op, 8'h07, 8'h40);
        check(seek_zero_o, 1'b1);
        wr_reg(ADDR_SCOUNT, 8'h99);
        while (seek_zero_o === 1'b1 && n < 50) begin
            @(negedge sys_clk_i);
            n++;
        end
        check(n, SK - 2);
        finish(1'b0, 8'h00);
        rd_reg(ADDR_SCOUNT, rv);
        check(rv, 8'h07);
    endtask : t_recal
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    initial begin
        #(40 * 30000);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (16) @(negedge sys_clk_i);
        rst_i = 1'b0;
        check(intrq_o, 1'b0);
        check(xfer_mode_o, XF_PIO);
        check(dmarq_o, 1'b0);
        t_dma_ok();
        t_dma_fatal();
        t_verify();
        t_setfeat();
        t_recal(8'h10);
        t_recal(8'h1f);
        issue(8'h00, 8'h01, 8'h00);
        finish(1'b1, FLT_ABRT);
        summarize();
    end
endmodule : tb
